// ===== dv/qdsd_decoder_properties.sv
`timescale 1ns/1ns
`default_nettype none
module qdsd_decoder_properties (
  // Clock and pins
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        variant_12bit,
  input wire logic        chip_select_n,
  input wire logic        serial_clk,
  input wire logic        serial_data,
  input wire logic        load_outputs_strobe_n,
  input wire logic        zero_reset_n,
  // Channel state
  input wire logic [11:0] input_code_a,
  input wire logic [11:0] input_code_b,
  input wire logic [11:0] input_code_c,
  input wire logic [11:0] input_code_d,
  input wire logic [11:0] output_code_a,
  input wire logic [11:0] output_code_b,
  input wire logic [11:0] output_code_c,
  input wire logic [11:0] output_code_d,
  input wire logic [3:0]  channel_shutdown
);
  logic [47:0] ins;
  logic [47:0] outs;
  assign ins  = {input_code_a, input_code_b, input_code_c, input_code_d};
  assign outs = {output_code_a, output_code_b, output_code_c, output_code_d};
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_cs_high_quiet:
    assert property ((chip_select_n && zero_reset_n)[*6] |=> $stable(ins)) else $error("input moved, cs high");
  a_strobe_follow:
    assert property ((!load_outputs_strobe_n)[*4] |=> outs == $past(ins)) else $error("outputs not following");
  a_strobe_latch:
    assert property ((load_outputs_strobe_n && zero_reset_n)[*6] |=> $stable(outs)) else $error("outputs moved");
  a_zero_clears:
    assert property ((!zero_reset_n)[*4] |=> ins == 48'h0 && outs == 48'h0) else $error("codes not zeroed");
  a_shdn_sticky:
    assert property (($past(channel_shutdown) & ~channel_shutdown) == 4'h0) else $error("shutdown bit dropped");
  a_shdn_keeps_codes:
    assert property ($changed(channel_shutdown) |-> $stable(ins)) else $error("shutdown word changed a code");
  a_short_code:
    assert property (!variant_12bit |-> {input_code_a[11:10], input_code_b[11:10], input_code_c[11:10],
      input_code_d[11:10]} == 8'h00) else $error("short code too wide");
  a_one_channel:
    assert property (zero_reset_n[*4] |-> $onehot0({$changed(input_code_a), $changed(input_code_b),
      $changed(input_code_c), $changed(input_code_d)})) else $error("several channels loaded");
endmodule
bind qdsd_decoder qdsd_decoder_properties u_props (.*);
`default_nettype wire

// ===== dv/qdsd_decoder_tb.sv
`timescale 1ns/1ns
`default_nettype none
module qdsd_decoder_tb;
  logic        clk = 0, srst = 1, v12 = 1, ldn = 1, zrn = 1;
  logic        cs_n, sclk, sdi;
  logic [11:0] ia, ib, ic, id, oa, ob, oc, od;
  logic [3:0]  sd;
  logic [3:0]  exp_sd = 4'h0;
  logic [11:0] exp_in [4] = '{default: 12'h000};
  logic [47:0] exp_out = 48'h0;
  logic [31:0] rs = 32'he717b73f;
  int          err_total = 0, cmp_count = 0, cyc = 0;
  initial forever #20 clk = ~clk;
  qdsd_decoder DUT (.clk(clk), .srst(srst), .variant_12bit(v12), .chip_select_n(cs_n), .serial_clk(sclk),
    .serial_data(sdi), .load_outputs_strobe_n(ldn), .zero_reset_n(zrn), .input_code_a(ia), .input_code_b(ib),
    .input_code_c(ic), .input_code_d(id), .output_code_a(oa), .output_code_b(ob), .output_code_c(oc),
    .output_code_d(od), .channel_shutdown(sd));
  qdsd_host_model HOST (.cs_n(cs_n), .sclk(sclk), .sdi(sdi));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [51:0] got, input logic [51:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic state_chk;
    if (!ldn) exp_out = {exp_in[0], exp_in[1], exp_in[2], exp_in[3]};
    chk({sd, ia, ib, ic, id}, {exp_sd, exp_in[0], exp_in[1], exp_in[2], exp_in[3]});
    chk({4'h0, oa, ob, oc, od}, {4'h0, exp_out});
  endtask
  task automatic send(input logic [17:0] w, input int n, input logic quiet);
    logic [15:0] y;
    y = v12 ? w[15:0] : {w[13:10], 2'h0, w[9:0]};
    HOST.send(w, n, quiet);
    if (!quiet) begin
      if (y[15]) exp_sd = 4'hf;
      else if (y[14]) exp_sd[y[13:12]] = 1'b1;
      else exp_in[y[13:12]] = y[11:0];
    end
    repeat (8) @(posedge clk);
    #1 state_chk();
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      complete_run();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) send({4'h0, i[1:0], 12'hfff - 12'(i)}, 16, 1'b0);
    send(18'h31a5c, 18, 1'b0);
    repeat (12) begin
      rs = xs(rs);
      send({2'h3, 1'b0, rs[14] & (rs[20:18] == 3'h0), rs[13:0]}, 16, 1'b0);
    end
    rs = xs(rs);
    send(rs[17:0], 16, 1'b1);
    @(posedge clk) ldn <= 1'b0;
    repeat (5) @(posedge clk);
    #1 state_chk();
    send(18'h02123, 16, 1'b0);
    @(posedge clk) ldn <= 1'b1;
    send(18'h03321, 16, 1'b0);
    @(posedge clk) zrn <= 1'b0;
    repeat (4) @(posedge clk);
    zrn <= 1'b1;
    exp_in = '{default: 12'h000};
    exp_out = 48'h0;
    repeat (3) @(posedge clk);
    #1 state_chk();
    for (int i = 0; i < 4; i++) send({4'h1, i[1:0], 12'habc}, 16, 1'b0);
    @(posedge clk) srst <= 1'b1;
    v12 <= 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    exp_sd = 4'h0;
    repeat (4) @(posedge clk);
    repeat (8) begin
      rs = xs(rs);
      send({4'hf, 2'b00, rs[11:0]}, rs[0] ? 16 : 14, 1'b0);
    end
    send(18'h02fff, 14, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire

// ===== dv/qdsd_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module qdsd_host_model (
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  // Quiet keeps cs high while clocking
  task automatic send(input logic [17:0] w, input int n, input logic quiet);
    cs_n = quiet;
    #137;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      #160;
      sclk = 1'b1;
      #160;
      sclk = 1'b0;
    end
    #140;
    cs_n = 1'b1;
    sdi = ~sdi;
    #300;
  endtask
endmodule
`default_nettype wire

// ===== logic/qdsd_decoder.sv
// Notes on behaviour
// - Word arrives MSB first; first bit received ends in the top position.
// - 16-bit word: global flag, channel flag, address high/low, 12-bit code.
// - 14-bit word: global flag, channel flag, address high/low, 10-bit code.
// - Global flag set shuts down all four channels regardless of other bits.
// - Channel flag alone shuts down the addressed channel, 00=A to 11=D.
// - Both flags clear loads the code into the addressed input register.
// - Code is unsigned binary over 4096 or 1024 steps.
// - With chip select high, clock and data toggling changes nothing.
// - Load strobe updates all four output registers together.
// - Synchronised active-low zero reset forces input and output code registers to zero code.
// - Chip select rising moves a word with both flags clear into the addressed input register.
// - Only the last 16 or 14 shifted bits are decoded.
// - Data shifts on rising serial clock only while chip select is low.
// - Strobe low makes outputs transparent; strobe rising latches them.
`timescale 1ns/1ns
`default_nettype none
module qdsd_decoder
  import qdsd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Variant select: 1 = 16-bit word, 0 = 14-bit word
  input  wire logic        variant_12bit,
  // Serial pins
  input  wire logic        chip_select_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_data,
  // Control pins
  input  wire logic        load_outputs_strobe_n,
  input  wire logic        zero_reset_n,
  // Channel state
  output logic [11:0]      input_code_a,
  output logic [11:0]      input_code_b,
  output logic [11:0]      input_code_c,
  output logic [11:0]      input_code_d,
  output logic [11:0]      output_code_a,
  output logic [11:0]      output_code_b,
  output logic [11:0]      output_code_c,
  output logic [11:0]      output_code_d,
  output logic [3:0]       channel_shutdown
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pins_s;
  logic       cs_n_s;
  logic       sclk_s;
  logic       sdi_s;
  logic       load_outputs_strobe_n_n_s;
  logic       zrst_n_s;

  qdsd_pin_sync #(
    .W (5)
  ) u_sync (
    .clk      (clk),
    .srst     (srst),
    .pin_in   ({chip_select_n, serial_clk, serial_data, load_outputs_strobe_n, zero_reset_n}),
    .rst_val  (5'h1b),
    .pin_sync (pins_s)
  );

  assign cs_n_s   = pins_s[4];
  assign sclk_s   = pins_s[3];
  assign sdi_s    = pins_s[2];
  assign load_outputs_strobe_n_n_s = pins_s[1];
  assign zrst_n_s = pins_s[0];

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  logic cs_prev_q;
  logic cs_prev_d;
  logic sclk_prev_q;
  logic sclk_prev_d;
  logic sclk_rise;
  logic cs_rise;

  always_comb begin
    cs_prev_d   = cs_n_s;
    sclk_prev_d = sclk_s;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cs_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_prev_q   <= cs_prev_d;
      sclk_prev_q <= sclk_prev_d;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign cs_rise   = cs_n_s & ~cs_prev_q;

  // ----------------------------------------
  // Word decode
  // ----------------------------------------
  function automatic qdsd_cmd_t decode_word(input logic [15:0] w, input logic v12);
    qdsd_cmd_t c;
    c = '0;
    if (v12) begin
      c.global_shutdown_flag  = w[W12_GLOBAL_POS];
      c.channel_shutdown_flag = w[W12_CHSD_POS];
      c.channel_addr_high     = w[W12_ADDRH_POS];
      c.channel_addr_low      = w[W12_ADDRL_POS];
      c.code                  = w[W12_CODE_MSB:0];
    end else begin
      c.global_shutdown_flag  = w[W10_GLOBAL_POS];
      c.channel_shutdown_flag = w[W10_CHSD_POS];
      c.channel_addr_high     = w[W10_ADDRH_POS];
      c.channel_addr_low      = w[W10_ADDRL_POS];
      c.code                  = {2'h0, w[W10_CODE_MSB:0]};
    end
    return c;
  endfunction

  // ----------------------------------------
  // Channel address decode
  // ----------------------------------------
  function automatic logic [3:0] chan_onehot(input logic hi, input logic lo);
    logic [3:0] sel;
    sel = 4'h0;
    unique case ({hi, lo})
      2'b00: sel = 4'h1;
      2'b01: sel = 4'h2;
      2'b10: sel = 4'h4;
      2'b11: sel = 4'h8;
    endcase
    return sel;
  endfunction

  // ----------------------------------------
  // Shift register
  // ----------------------------------------
  logic [15:0] shift_q;
  logic [15:0] shift_d;

  always_comb begin
    shift_d = shift_q;
    if (!cs_n_s && sclk_rise) begin
      shift_d = {shift_q[14:0], sdi_s};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      shift_q <= SHIFT_RESET;
    end else begin
      shift_q <= shift_d;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  qdsd_cmd_t   cmd;
  logic [3:0]  chan_sel;
  logic        word_taken;
  logic        zero_hold;
  logic        load_word;

  // Old shift contents decode if cs rises during a shift
  assign cmd        = decode_word(shift_q, variant_12bit);
  assign chan_sel   = chan_onehot(cmd.channel_addr_high, cmd.channel_addr_low);
  assign word_taken = cs_rise;
  assign zero_hold  = ~zrst_n_s;
  assign load_word  = word_taken & ~cmd.global_shutdown_flag & ~cmd.channel_shutdown_flag;

  // ----------------------------------------
  // Shutdown state
  // ----------------------------------------
  // Sticky: no word clears it, only srst
  logic [3:0] shdn_q;
  logic [3:0] shdn_d;

  always_comb begin
    shdn_d = shdn_q;
    if (word_taken) begin
      if (cmd.global_shutdown_flag) begin
        shdn_d = 4'hf;
      end else if (cmd.channel_shutdown_flag) begin
        shdn_d = shdn_q | chan_sel;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      shdn_q <= SHDN_RESET;
    end else begin
      shdn_q <= shdn_d;
    end
  end

  // ----------------------------------------
  // Input registers
  // ----------------------------------------
  logic [11:0] in_q [NUM_CHAN];
  logic [11:0] in_d [NUM_CHAN];

  // Zero reset wins over a word taken in the same cycle
  always_comb begin
    in_d = in_q;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (zero_hold) begin
        in_d[i] = CODE_RESET;
      end else if (load_word && chan_sel[i]) begin
        in_d[i] = cmd.code;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        in_q[i] <= CODE_RESET;
      end
    end else begin
      in_q <= in_d;
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  logic [11:0] out_q [NUM_CHAN];
  logic [11:0] out_d [NUM_CHAN];

  // Transparent while strobe low, one clock behind the inputs
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (zero_hold) begin
        out_d[i] = CODE_RESET;
      end else if (!load_outputs_strobe_n_n_s) begin
        out_d[i] = in_q[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        out_q[i] <= CODE_RESET;
      end
    end else begin
      out_q <= out_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign input_code_a     = in_q[0];
  assign input_code_b     = in_q[1];
  assign input_code_c     = in_q[2];
  assign input_code_d     = in_q[3];
  assign output_code_a    = out_q[0];
  assign output_code_b    = out_q[1];
  assign output_code_c    = out_q[2];
  assign output_code_d    = out_q[3];
  assign channel_shutdown = shdn_q;

endmodule
`default_nettype wire

// ===== logic/qdsd_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module qdsd_pin_sync
  import qdsd_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Asynchronous pins and their synchronised copies
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
  end

  // Idle value must be a constant tie-off from the parent
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= rst_val;
      sync_q <= rst_val;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pin_sync = sync_q;

endmodule
`default_nettype wire

// ===== shared/qdsd_pkg.sv
package qdsd_pkg;

  // ----------------------------------------
  // Word variants
  // ----------------------------------------
  localparam int unsigned WORD12_BITS = 16;
  localparam int unsigned WORD10_BITS = 14;
  localparam int unsigned CODE12_BITS = 12;
  localparam int unsigned CODE10_BITS = 10;
  localparam int unsigned CODE_BITS   = 12;
  localparam int unsigned STEPS12     = 4096;
  localparam int unsigned STEPS10     = 1024;
  localparam int unsigned NUM_CHAN    = 4;

  // ----------------------------------------
  // Field positions, 16-bit word
  // ----------------------------------------
  localparam int unsigned W12_GLOBAL_POS = 15;
  localparam int unsigned W12_CHSD_POS   = 14;
  localparam int unsigned W12_ADDRH_POS  = 13;
  localparam int unsigned W12_ADDRL_POS  = 12;
  localparam int unsigned W12_CODE_MSB   = 11;

  // ----------------------------------------
  // Field positions, 14-bit word
  // ----------------------------------------
  localparam int unsigned W10_GLOBAL_POS = 13;
  localparam int unsigned W10_CHSD_POS   = 12;
  localparam int unsigned W10_ADDRH_POS  = 11;
  localparam int unsigned W10_ADDRL_POS  = 10;
  localparam int unsigned W10_CODE_MSB   = 9;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [11:0] CODE_RESET  = 12'h000;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [3:0]  SHDN_RESET  = 4'h0;

  // ----------------------------------------
  // Decoded command word
  // ----------------------------------------
  typedef struct packed {
    logic        global_shutdown_flag;
    logic        channel_shutdown_flag;
    logic        channel_addr_high;
    logic        channel_addr_low;
    logic [11:0] code;
  } qdsd_cmd_t;

endpackage
